// ### design/dac_config_regs.sv
// Analog configuration register bank with converter clock and soft-start.
// Assumes a synchronous register port; analog macros sit outside.
//
// What this block does
// - Ramp DAC ceiling register, 8 bits, reset zero, scales ramp +-40%.
// - Bias bit 2 picks external reference; keep internal default zero.
// - Bias bits 1-0: off, 0.5nA default, 1nA pixel sink current.
// - Pump-hold bit 4 stops converter switching while gamma sampling.
// - Gamma bit 3 enables sample-and-hold; zero bypasses it.
// - Gamma step bits 2-0 select reference over 2^(7-code), reset 0.
// - Mode bits 1-0: first auto 00, second auto 01, manual 10.
// - First auto mode regulates current from dimming and reference.
// - Second auto mode regulates current, clamped at manual level.
// - Manual mode holds fixed cathode voltage from manual level.
// - Manual level acts only for modes 01 or 10; reset 51h.
// - Control bit 7 zero keeps soft-start, one skips it.
// - Duty bits 6-4 set clock high:low 1:7 to 7:1, reset 3.
// - Rate bits 3-2 give 125, 250, 500, 800 kHz, reset 3.
// - Soft-start bits 1-0 give 2, 4, 8, 16 ms ramp, reset 4 ms.
// - Pixel voltage ceiling register, 8 bits, reset 0Dh.
// - Reference current: coarse bits 7-5, fine bits 4-0.
// - Reference 30h default is unity luminance, plus half per 10h.
`timescale 1ns/100ps
`include "dac_consts.svh"

module dac_config_regs
#(
	parameter int SS_BASE_CYC = `DAC_SS_BASE_CYC
)
(
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	// Register port
	input  wire dac_pkg::dac_req_t req,
	output logic [7:0]             rdData,
	// Gamma sampling window from the sensor timing
	input  wire logic              gammaSampling,
	// Analog controls
	output dac_pkg::dac_ana_t      ana,
	// Converter drive
	output logic                   convClk,
	output logic                   convRun,
	output logic                   softStartBusy
);
	import dac_pkg::*;

	// Every check below runs on the system clock and sleeps in reset
	default clocking sysCb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	// =====================================================
	// Register storage
	// =====================================================
	logic [7:0] rampQ;
	logic [7:0] biasQ;
	logic [7:0] gammaQ;
	logic [7:0] modeQ;
	logic [7:0] convQ;
	logic [7:0] vgceilQ;
	logic [7:0] cathQ;
	logic [7:0] irefQ;

	// Write decode; full byte kept so odd codes read back unchanged
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rampQ   <= `DAC_RST_RAMP;
			biasQ   <= `DAC_RST_BIAS;
			gammaQ  <= `DAC_RST_GAMMA;
			modeQ   <= `DAC_RST_MODE;
			convQ   <= `DAC_RST_CONV;
			vgceilQ <= `DAC_RST_VGCEIL;
			cathQ   <= `DAC_RST_CATH;
			irefQ   <= `DAC_RST_IREF;
		end
		else if (req.wrStb)
		begin
			case (req.addr)
				`DAC_OFF_RAMP:   rampQ   <= req.wrData;
				`DAC_OFF_BIAS:   biasQ   <= req.wrData;
				`DAC_OFF_GAMMA:  gammaQ  <= req.wrData;
				`DAC_OFF_MODE:   modeQ   <= req.wrData;
				`DAC_OFF_CONV:   convQ   <= req.wrData;
				`DAC_OFF_VGCEIL: vgceilQ <= req.wrData;
				`DAC_OFF_CATH:   cathQ   <= req.wrData;
				`DAC_OFF_IREF:   irefQ   <= req.wrData;
				default:         ;
			endcase
		end
	end

	// Read data one cycle after the strobe; unmapped reads as zero
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			rdData <= 8'h00;
		else if (req.rdStb)
		begin
			case (req.addr)
				`DAC_OFF_RAMP:   rdData <= rampQ;
				`DAC_OFF_BIAS:   rdData <= biasQ;
				`DAC_OFF_GAMMA:  rdData <= gammaQ;
				`DAC_OFF_MODE:   rdData <= modeQ;
				`DAC_OFF_CONV:   rdData <= convQ;
				`DAC_OFF_VGCEIL: rdData <= vgceilQ;
				`DAC_OFF_CATH:   rdData <= cathQ;
				`DAC_OFF_IREF:   rdData <= irefQ;
				default:         rdData <= 8'h00;
			endcase
		end
		else
			rdData <= 8'h00;
	end

	// =====================================================
	// Analog control outputs
	// =====================================================
	// Registered so every output leaves straight from a flip-flop
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			ana <= '0;
		else
		begin
			ana.rampCeiling                <= rampQ;
			ana.externalReferenceSelect    <= biasQ[`DAC_BIAS_EXTREF];
			ana.pixelBiasSelect            <= biasQ[1:0];
			ana.gammaSenseSampleHoldEnable <= gammaQ[`DAC_GAMMA_SH];
			ana.gammaSensorStep            <= gammaQ[2:0];
			ana.cathodeCurrentSenseEnable  <= modeQ[3:2];
			ana.cathodeRegulationMode      <= modeQ[1:0];
			ana.pixelVoltageCeiling        <= vgceilQ;
			ana.cathodeLevel               <= cathQ;
			// Level used as clamp or setpoint only in modes 01 and 10
			ana.cathodeLevelActive <= (modeQ[1:0] == DAC_MODE_AUTO_SECOND) ||
				(modeQ[1:0] == DAC_MODE_MANUAL);
			ana.referenceCurrentCoarse     <= irefQ[7:5];
			ana.referenceCurrentFine       <= irefQ[4:0];
		end
	end

	// =====================================================
	// Converter clock generator
	// =====================================================
	// System cycles per eighth of a period, one eighth per duty step
	function automatic logic [7:0] eighthCycles(input logic [1:0] rate);
		case (rate)
			2'h0:    eighthCycles = 8'(`DAC_CK125_HALF);
			2'h1:    eighthCycles = 8'(`DAC_CK250_HALF);
			2'h2:    eighthCycles = 8'(`DAC_CK500_HALF);
			default: eighthCycles = 8'(`DAC_CK800_HALF);
		endcase
	endfunction

	// High eighths per period: 1,2,3,4,5,6,7; code 7 treated as 1:1
	function automatic logic [2:0] highEighths(input logic [2:0] duty);
		case (duty)
			3'h0:    highEighths = 3'h1;
			3'h1:    highEighths = 3'h2;
			3'h2:    highEighths = 3'h3;
			3'h4:    highEighths = 3'h5;
			3'h5:    highEighths = 3'h6;
			3'h6:    highEighths = 3'h7;
			default: highEighths = 3'h4;
		endcase
	endfunction

	logic [7:0] tickCntQ;
	logic [2:0] phaseQ;
	logic       tickEnd;
	assign tickEnd = (tickCntQ >= eighthCycles(convQ[3:2]) - 8'h01);

	// Eighth-period ticks and phase counter
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tickCntQ <= 8'h00;
			phaseQ   <= 3'h0;
		end
		else if (tickEnd)
		begin
			tickCntQ <= 8'h00;
			phaseQ   <= phaseQ + 3'h1;
		end
		else
			tickCntQ <= tickCntQ + 8'h01;
	end

	// Switching clock, gated while the gamma sense is being sampled
	logic pumpHold;
	assign pumpHold = gammaQ[`DAC_GAMMA_HOLD] && gammaSampling;
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			convClk <= 1'b0;
		else if (pumpHold)
			convClk <= 1'b0;
		else
			convClk <= (phaseQ < highEighths(convQ[6:4]));
	end

	// =====================================================
	// Soft-start sequencer
	// =====================================================
	typedef enum logic [1:0]
	{
		SS_IDLE = 2'b00,
		SS_RAMP = 2'b01,
		SS_RUN  = 2'b10
	} dac_ss_t;

	dac_ss_t     ssQ;
	logic [31:0] ssCntQ;
	logic [31:0] ssLen;
	// 2, 4, 8 or 16 ms as base shifted by code
	assign ssLen = SS_BASE_CYC << convQ[1:0];

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ssQ    <= SS_IDLE;
			ssCntQ <= 32'h0000_0000;
		end
		else
		begin
			case (ssQ)
				SS_IDLE:
				begin
					ssCntQ <= 32'h0000_0000;
					ssQ    <= convQ[`DAC_CONV_SSBYP] ? SS_RUN : SS_RAMP;
				end
				SS_RAMP:
				begin
					if (convQ[`DAC_CONV_SSBYP] || ssCntQ >= ssLen - 32'h1)
						ssQ <= SS_RUN;
					else
						ssCntQ <= ssCntQ + 32'h1;
				end
				SS_RUN:  ssQ <= SS_RUN;
				default: ssQ <= SS_IDLE;
			endcase
		end
	end

	// Status flags toward the converter
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			convRun       <= 1'b0;
			softStartBusy <= 1'b0;
		end
		else
		begin
			convRun       <= (ssQ == SS_RUN);
			softStartBusy <= (ssQ == SS_RAMP);
		end
	end

	// =====================================================
	// Checks
	// =====================================================
	sequence wrGamma;
		req.wrStb && req.addr == `DAC_OFF_GAMMA;
	endsequence

	// One strobe on the register port at a given index
	sequence wrAt(logic [7:0] a);
		req.wrStb && req.addr == a;
	endsequence

	sequence rdAt(logic [7:0] a);
		req.rdStb && req.addr == a;
	endsequence

	// Fields forwarded, stored, read back and acted on; nrst in front skips the edge that releases reset
	chk_ramp_readback: assert property (wrAt(`DAC_OFF_RAMP) ##1
		rdAt(`DAC_OFF_RAMP) |=> rdData == $past(req.wrData, 2))
		else $error("ramp ceiling readback mismatch");
	chk_bias_field: assert property (nrst |=>
		ana.pixelBiasSelect == $past(biasQ[1:0]))
		else $error("pixel bias field not forwarded");
	chk_extref_bit: assert property (nrst |=>
		ana.externalReferenceSelect == $past(biasQ[2]))
		else $error("reference select not forwarded");
	chk_pump_hold: assert property (gammaQ[4] && gammaSampling |=>
		!convClk)
		else $error("converter switched during gamma sampling");
	chk_gamma_step: assert property (wrGamma |=> ##1
		ana.gammaSensorStep == $past(req.wrData[2:0], 2) &&
		ana.gammaSenseSampleHoldEnable == $past(req.wrData[3], 2))
		else $error("gamma step or hold not applied");
	chk_level_active: assert property (nrst |=>
		ana.cathodeLevelActive == ($past(modeQ[1:0]) == 2'h1 ||
		$past(modeQ[1:0]) == 2'h2))
		else $error("cathode level active in wrong mode");
	chk_undef_store: assert property (wrAt(`DAC_OFF_MODE) |=>
		modeQ == $past(req.wrData))
		else $error("mode byte not stored whole");
	chk_ss_bypass: assert property (ssQ == SS_RAMP && convQ[7] |=>
		ssQ == SS_RUN)
		else $error("soft-start not skipped");
	chk_iref_split: assert property (nrst |=>
		{ana.referenceCurrentCoarse, ana.referenceCurrentFine} ==
		$past(irefQ))
		else $error("reference current split wrong");

	// Whole bytes stored at the strobe edge, odd codes included
	chk_ramp_store: assert property (wrAt(`DAC_OFF_RAMP) |=>
		rampQ == $past(req.wrData))
		else $error("ramp ceiling byte not stored");
	chk_bias_store: assert property (wrAt(`DAC_OFF_BIAS) |=>
		biasQ == $past(req.wrData))
		else $error("pixel bias byte not stored");
	chk_gamma_store: assert property (wrAt(`DAC_OFF_GAMMA) |=>
		gammaQ == $past(req.wrData))
		else $error("gamma sensor byte not stored");
	chk_conv_store: assert property (wrAt(`DAC_OFF_CONV) |=>
		convQ == $past(req.wrData))
		else $error("converter control byte not stored");
	chk_vgceil_store: assert property (wrAt(`DAC_OFF_VGCEIL) |=>
		vgceilQ == $past(req.wrData))
		else $error("pixel voltage ceiling byte not stored");
	chk_cath_store: assert property (wrAt(`DAC_OFF_CATH) |=>
		cathQ == $past(req.wrData))
		else $error("cathode level byte not stored");
	chk_iref_store: assert property (wrAt(`DAC_OFF_IREF) |=>
		irefQ == $past(req.wrData))
		else $error("reference current byte not stored");

	// Read data follow the strobe by one cycle and stand only then
	chk_bias_readback: assert property (rdAt(`DAC_OFF_BIAS) |=>
		rdData == $past(biasQ))
		else $error("pixel bias readback mismatch");
	chk_gamma_readback: assert property (rdAt(`DAC_OFF_GAMMA) |=>
		rdData == $past(gammaQ))
		else $error("gamma sensor readback mismatch");
	chk_conv_readback: assert property (rdAt(`DAC_OFF_CONV) |=>
		rdData == $past(convQ))
		else $error("converter control readback mismatch");
	chk_vgceil_readback: assert property (rdAt(`DAC_OFF_VGCEIL) |=>
		rdData == $past(vgceilQ))
		else $error("pixel voltage ceiling readback mismatch");
	chk_cath_readback: assert property (rdAt(`DAC_OFF_CATH) |=>
		rdData == $past(cathQ))
		else $error("cathode level readback mismatch");
	chk_iref_readback: assert property (rdAt(`DAC_OFF_IREF) |=>
		rdData == $past(irefQ))
		else $error("reference current readback mismatch");
	chk_unmapped_read: assert property (req.rdStb &&
		(req.addr < `DAC_OFF_RAMP || req.addr > `DAC_OFF_IREF) |=>
		rdData == 8'h00)
		else $error("unmapped index read not zero");
	chk_read_idle: assert property (!req.rdStb |=>
		rdData == 8'h00)
		else $error("read data stood past its cycle");

	// Converter clock: one phase step per eighth, level from duty
	chk_phase_step: assert property (nrst && tickEnd |=>
		phaseQ == $past(phaseQ) + 3'h1)
		else $error("converter phase did not advance");
	chk_tick_count: assert property (nrst && !tickEnd |=>
		tickCntQ == $past(tickCntQ) + 8'h01)
		else $error("eighth-period counter skipped");
	chk_duty_level: assert property (nrst && !pumpHold |=>
		convClk == ($past(phaseQ) < highEighths($past(convQ[6:4]))))
		else $error("converter clock level wrong for duty");

	// Soft-start ramp counts one a cycle; a run, once begun, stays
	chk_ss_count: assert property (ssQ == SS_RAMP &&
		!convQ[`DAC_CONV_SSBYP] && ssCntQ < ssLen - 32'h1 |=>
		ssQ == SS_RAMP && ssCntQ == $past(ssCntQ) + 32'h1)
		else $error("soft-start counter did not advance");
	chk_run_sticky: assert property (convRun |=> convRun)
		else $error("converter run dropped");
	chk_busy_excl: assert property (!(convRun && softStartBusy))
		else $error("soft-start busy while running");

endmodule // dac_config_regs

// ### shared/dac_consts.svh
// Offsets, field positions, reset values and timing counts for the
// analog configuration register bank.
// Assumes an 8-bit register port addressed by register index.
`ifndef DAC_CONSTS_SVH
`define DAC_CONSTS_SVH

// Register offsets
`define DAC_OFF_RAMP      8'h08
`define DAC_OFF_BIAS      8'h09
`define DAC_OFF_GAMMA     8'h0A
`define DAC_OFF_MODE      8'h0B
`define DAC_OFF_CONV      8'h0C
`define DAC_OFF_VGCEIL    8'h0D
`define DAC_OFF_CATH      8'h0E
`define DAC_OFF_IREF      8'h0F

// Reset values
`define DAC_RST_RAMP      8'h00
`define DAC_RST_BIAS      8'h01
`define DAC_RST_GAMMA     8'h00
`define DAC_RST_MODE      8'h00
`define DAC_RST_CONV      8'h3D
`define DAC_RST_VGCEIL    8'h0D
`define DAC_RST_CATH      8'h51
`define DAC_RST_IREF      8'h30

// Field positions
`define DAC_BIAS_EXTREF   2
`define DAC_GAMMA_HOLD    4
`define DAC_GAMMA_SH      3
`define DAC_CONV_SSBYP    7

// Timing: converter clock rates and soft-start base time
`define DAC_SYS_HZ        40000000
`define DAC_SS_BASE_MS    2
`define DAC_SS_BASE_CYC   (`DAC_SYS_HZ / 1000 * `DAC_SS_BASE_MS)
`define DAC_CK125_HALF    (`DAC_SYS_HZ / 125000 / 8)
`define DAC_CK250_HALF    (`DAC_SYS_HZ / 250000 / 8)
`define DAC_CK500_HALF    (`DAC_SYS_HZ / 500000 / 8)
`define DAC_CK800_HALF    (`DAC_SYS_HZ / 800000 / 8)

`endif

// ### shared/dac_pkg.sv
// Types for the analog configuration register bank.
// Assumes the constants header is included by its users.
package dac_pkg;

	// Cathode supply mode field encodings
	typedef enum logic [1:0]
	{
		DAC_MODE_AUTO_FIRST  = 2'h0,
		DAC_MODE_AUTO_SECOND = 2'h1,
		DAC_MODE_MANUAL = 2'h2,
		DAC_MODE_UNDEF  = 2'h3
	} dac_mode_t;

	// Register port request
	typedef struct packed
	{
		logic       wrStb;
		logic       rdStb;
		logic [7:0] addr;
		logic [7:0] wrData;
	} dac_req_t;

	// Decoded analog controls toward the converter and array
	typedef struct packed
	{
		logic [7:0] rampCeiling;
		logic [1:0] pixelBiasSelect;
		logic       externalReferenceSelect;
		logic       gammaSenseSampleHoldEnable;
		logic [2:0] gammaSensorStep;
		logic [1:0] cathodeCurrentSenseEnable;
		logic [1:0] cathodeRegulationMode;
		logic [7:0] pixelVoltageCeiling;
		logic [7:0] cathodeLevel;
		logic       cathodeLevelActive;
		logic [2:0] referenceCurrentCoarse;
		logic [4:0] referenceCurrentFine;
	} dac_ana_t;

endpackage

// ### verification/test_display_analog_config_regs.sv
// Self-checking bench for the analog configuration register bank.
// Assumes the bank alone on one 40 MHz clock, driven over its plain port.
`timescale 1ns/100ps

module test_display_analog_config_regs;
	import dac_pkg::*;

	// ==========================================
	// Signals and tables
	logic       sys_clk;
	logic       nrst;
	dac_req_t   req;
	logic       gammaSampling;
	logic [7:0] rdData;
	dac_ana_t   ana;
	logic       convClk;
	logic       convRun;
	logic       softStartBusy;
	int         errTotal;
	int         compares;
	int         n;
	int         hi;
	int         lo;
	int         bad;
	logic [7:0] d;
	dac_ana_t   e;
	// Reset values and write patterns, undefined codes on purpose
	logic [7:0] rstv [8] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h3D, 8'h0D,
		8'h51, 8'h30};
	logic [7:0] pat  [8] = '{8'h78, 8'h03, 8'h1F, 8'h0F, 8'hF0, 8'hFF,
		8'hA5, 8'h80};
	// Cycles per eighth of a converter period, by rate code
	int         eig  [4] = '{40, 20, 10, 6};

	// Short soft-start base keeps the ramp a few dozen cycles
	dac_config_regs #(.SS_BASE_CYC(10)) dut
	(
		.sys_clk       (sys_clk),
		.nrst          (nrst),
		.req           (req),
		.rdData        (rdData),
		.gammaSampling (gammaSampling),
		.ana           (ana),
		.convClk       (convClk),
		.convRun       (convRun),
		.softStartBusy (softStartBusy)
	);

	// 40 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ==========================================
	// Tasks
	task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
		compares++;
		if (got !== exp)
		begin
			errTotal++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Sample after the edge's updates have landed
	task automatic step();
		@(posedge sys_clk);
		#1;
		n++;
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] v);
		@(posedge sys_clk);
		req.wrStb  <= 1'b1;
		req.addr   <= a;
		req.wrData <= v;
		@(posedge sys_clk);
		req.wrStb  <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		req.rdStb <= 1'b1;
		req.addr  <= a;
		@(posedge sys_clk);
		req.rdStb <= 1'b0;
		#1;
		v = rdData;
	endtask

	// One whole converter period; bounded so a dead clock cannot hang
	task automatic meas();
		n = 0;
		hi = 0;
		lo = 0;
		while (convClk !== 1'b0 && n < 2000) step();
		while (convClk !== 1'b1 && n < 2000) step();
		while (convClk === 1'b1 && n < 2000)
		begin
			step();
			hi++;
		end
		while (convClk === 1'b0 && n < 2000)
		begin
			step();
			lo++;
		end
	endtask

	task automatic stopTest();
		if (errTotal == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ==========================================
	// Sequence
	initial
	begin
		nrst = 1'b0;
		req = '0;
		gammaSampling = 1'b0;
		errTotal = 0;
		compares = 0;
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		// Soft start at reset code 1 lasts twice the base
		n = 0;
		while (softStartBusy !== 1'b1 && n < 50) step();
		hi = 0;
		while (softStartBusy === 1'b1 && hi < 500)
		begin
			step();
			hi++;
		end
		chk("softStartCycles", 20, hi);
		step();
		chk("convRun", 1, convRun);
		e = '{8'h00, 2'h1, 1'b0, 1'b0, 3'h0, 2'h0, 2'h0, 8'h0D, 8'h51,
			1'b0, 3'h1, 5'h10};
		chk("anaReset", e, ana);
		// Reset values, then write and read back every register
		for (int i = 0; i < 8; i++)
		begin
			rd(8'(8'h08 + i), d);
			chk("resetValue", rstv[i], d);
		end
		for (int i = 0; i < 8; i++)
			wr(8'(8'h08 + i), pat[i]);
		for (int i = 0; i < 8; i++)
		begin
			rd(8'(8'h08 + i), d);
			chk("readBack", pat[i], d);
		end
		step();
		chk("rdIdle", 0, rdData);
		e = '{8'h78, 2'h3, 1'b0, 1'b1, 3'h7, 2'h3, 2'h3, 8'hFF, 8'hA5,
			1'b0, 3'h4, 5'h00};
		chk("anaFields", e, ana);
		// Every supply mode code and the manual level's reach
		for (int m = 0; m < 4; m++)
		begin
			wr(8'h0B, 8'(m));
			step();
			step();
			chk("regMode", m, ana.cathodeRegulationMode);
			chk("levelActive", m == 1 || m == 2, ana.cathodeLevelActive);
		end
		// Unmapped places are ignored and read as zero
		wr(8'h10, 8'hAA);
		wr(8'h07, 8'hAA);
		rd(8'h10, d);
		chk("unmapped10", 0, d);
		rd(8'h07, d);
		chk("unmapped07", 0, d);
		// Write then read with no gap
		@(posedge sys_clk);
		req.wrStb  <= 1'b1;
		req.addr   <= 8'h08;
		req.wrData <= 8'h5A;
		@(posedge sys_clk);
		req.wrStb  <= 1'b0;
		req.rdStb  <= 1'b1;
		@(posedge sys_clk);
		req.rdStb  <= 1'b0;
		#1;
		chk("backToBack", 8'h5A, rdData);
		// Every rate at even duty; first period may be cut by the change
		for (int r = 0; r < 4; r++)
		begin
			wr(8'h0C, {1'b0, 3'h3, 2'(r), 2'h1});
			meas();
			meas();
			chk("clkHigh", 4 * eig[r], hi);
			chk("clkPeriod", 8 * eig[r], hi + lo);
		end
		for (int c = 0; c < 7; c++)
		begin
			wr(8'h0C, {1'b0, 3'(c), 2'h3, 2'h1});
			meas();
			meas();
			chk("dutyHigh", 6 * (c + 1), hi);
		end
		// Pump hold silences the converter only while sampling
		wr(8'h0C, 8'h3D);
		// Step code kept at 7, so no settling wait before sampling
		wr(8'h0A, 8'h17);
		@(posedge sys_clk);
		gammaSampling <= 1'b1;
		step();
		step();
		bad = 0;
		repeat (100)
		begin
			step();
			if (convClk !== 1'b0)
				bad++;
		end
		chk("pumpHold", 0, bad);
		@(posedge sys_clk);
		gammaSampling <= 1'b0;
		meas();
		meas();
		chk("pumpResume", 24, hi);
		wr(8'h0A, 8'h07);
		@(posedge sys_clk);
		gammaSampling <= 1'b1;
		meas();
		meas();
		chk("holdDisabled", 24, hi);
		// Mid-run reset: home values again, ramp cut short by a write
		@(posedge sys_clk);
		nrst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		wr(8'h0C, 8'hBD);
		step();
		step();
		chk("bypassRun", 1, convRun);
		chk("bypassBusy", 0, softStartBusy);
		rd(8'h08, d);
		chk("midReset", 8'h00, d);
		stopTest();
	end

	// Watchdog at twenty thousand cycles, some five times the full run
	initial
	begin
		#500000;
		errTotal++;
		stopTest();
	end

endmodule // test_display_analog_config_regs
